// ### adc_seq_pkg.sv
// shared constants, types and helpers for the converter command sequencer
// Notes on behaviour
// - byte 06h resets the device
// - 40h family byte plus data writes register
// - 2xh byte returns one configuration register
// - byte 08h starts conversions, continuous keeps going
// - ready output falls on new result
// - byte 10h returns latest result, three bytes
// - byte 02h stops conversions, enters sleep
// - selector 1110 shorts inputs to mid-supply
// - gains above 4 need the amplifier
// - gain selection includes setting of 32
// - bypass bit routes inputs around amplifier
package adc_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command bytes
  localparam logic [7:0] CMD_RESET       = 8'h06;
  localparam logic [7:0] CMD_START       = 8'h08;
  localparam logic [7:0] CMD_SLEEP       = 8'h02;
  localparam logic [7:0] CMD_READ_DATA   = 8'h10;
  localparam logic [3:0] REG_WRITE_NIB   = 4'h4;
  localparam logic [3:0] REG_READ_NIB    = 4'h2;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers and fields
  localparam int         REG_COUNT       = 4;
  localparam logic [1:0] REG_CONFIG0     = 2'h0;
  localparam logic [1:0] REG_CONFIG1     = 2'h1;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam int         SEL_MSB         = 7;
  localparam int         SEL_LSB         = 4;
  localparam int         GAIN_MSB        = 3;
  localparam int         GAIN_LSB        = 1;
  localparam int         BYPASS_BIT      = 0;
  localparam int         CONT_BIT        = 3;
  localparam logic [3:0] SEL_SHORTED     = 4'he;
  localparam logic [2:0] GAIN_CODE_4     = 3'h2;
  localparam logic [2:0] GAIN_CODE_32    = 3'h5;
  localparam logic [1:0] RESULT_BYTES    = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int POWER_UP_TIME_US        = 500;
  localparam int CLK_FREQ_KHZ            = 10000;
  localparam int POWER_UP_CYCLES_DEFAULT = (POWER_UP_TIME_US * CLK_FREQ_KHZ + 999) / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer states
  typedef enum logic [1:0] {
    ST_BOOT  = 2'b00,
    ST_IDLE  = 2'b01,
    ST_WDATA = 2'b10,
    ST_SEND  = 2'b11
  } seq_state_type;

  // register index carried in bits 3:2 of a register command
  function automatic logic [1:0] cmd_reg_index(input logic [7:0] cmd);
    return cmd[3:2];
  endfunction : cmd_reg_index

endpackage : adc_seq_pkg

// ### byte_stream_if.sv
// valid/ready byte stream between sequencer parts
`timescale 1ns/100ps
interface byte_stream_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface : byte_stream_if

// ### byte_buffer2.sv
// two-entry byte buffer with valid/ready on both sides
`timescale 1ns/100ps
module byte_buffer2
  import adc_seq_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      sys_rst_i,
  byte_stream_if.sink    in_s,
  byte_stream_if.source  out_s
);

  typedef struct packed {
    logic [1:0][7:0] mem;
    logic            wr_ptr;
    logic            rd_ptr;
    logic [1:0]      count;
  } buf_state_type;

  buf_state_type q;
  buf_state_type d;
  logic          push;
  logic          pop;

  assign in_s.ready  = (q.count != 2'h2);
  assign out_s.valid = (q.count != 2'h0);
  assign out_s.data  = q.mem[q.rd_ptr];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr_ptr] = in_s.data;
      d.wr_ptr        = ~q.wr_ptr;
    end
    if (pop) begin
      d.rd_ptr = ~q.rd_ptr;
    end
    if (push && !pop) begin
      d.count = q.count + 2'h1;
    end else if (pop && !push) begin
      d.count = q.count - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : byte_buffer2

// ### config_regs.sv
// configuration register file of four bytes
`timescale 1ns/100ps
module config_regs
  import adc_seq_pkg::*;
(
  input  wire logic                           clk_i,
  input  wire logic                           sys_rst_i,
  input  wire logic                           clear_i,
  input  wire logic                           wr_en_i,
  input  wire logic [1:0]                     wr_idx_i,
  input  wire logic [7:0]                     wr_data_i,
  input  wire logic [1:0]                     rd_idx_i,
  output logic      [7:0]                     rd_data_o,
  output logic      [REG_COUNT-1:0][7:0]      regs_o
);

  typedef struct packed {
    logic [REG_COUNT-1:0][7:0] regs;
  } regs_state_type;

  regs_state_type q;
  regs_state_type d;

  assign rd_data_o = q.regs[rd_idx_i];
  assign regs_o    = q.regs;

  always_comb begin
    d = q;
    if (clear_i) begin
      d.regs = {REG_COUNT{REG_RESET_VALUE}};
    end else if (wr_en_i) begin
      d.regs[wr_idx_i] = wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q <= {REG_COUNT{REG_RESET_VALUE}};
    end else begin
      q <= d;
    end
  end

endmodule : config_regs

// ### adc_command_sequencer.sv
// command interpreter of the converter: decode, config, result hand-out
`timescale 1ns/100ps
module adc_command_sequencer
  import adc_seq_pkg::*;
#(
  parameter int unsigned POWER_UP_CYCLES = POWER_UP_CYCLES_DEFAULT
)
(
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic [7:0]                cmd_data_i,
  input  wire logic                      cmd_valid_i,
  output logic                           cmd_ready_o,
  output logic      [7:0]                rsp_data_o,
  output logic                           rsp_valid_o,
  input  wire logic                      rsp_ready_i,
  input  wire logic [23:0]               conv_result_i,
  input  wire logic                      conv_done_i,
  output logic                           conv_run_o,
  output logic                           conv_start_o,
  output logic                           power_down_o,
  output logic                           result_ready_n_o,
  output logic      [3:0]                input_selector_o,
  output logic                           inputs_shorted_o,
  output logic                           amp_bypass_o,
  output logic      [2:0]                gain_code_o,
  output logic      [REG_COUNT-1:0][7:0] config_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    seq_state_type state;
    logic [12:0]   boot_cnt;
    logic [1:0]    widx;
    logic [23:0]   latest;
    logic [23:0]   shift;
    logic [1:0]    left;
    logic          run;
    logic          start_pulse;
    logic          pdown;
    logic          rdy_n;
    logic [3:0]    sel;
    logic          shorted;
    logic          bypass;
    logic [2:0]    gain;
    logic [REG_COUNT-1:0][7:0] cfg;
  } seq_state_struct_type;

  localparam logic [12:0] BOOT_LAST = 13'(POWER_UP_CYCLES - 1);

  seq_state_struct_type      q;
  seq_state_struct_type      d;
  logic                      cmd_take;
  logic                      reg_clear;
  logic                      reg_wr_en;
  logic [1:0]                reg_rd_idx;
  logic [7:0]                reg_rd_data;
  logic [REG_COUNT-1:0][7:0] regs_all;
  logic [2:0]                gain_field;
  logic                      bypass_field;

  byte_stream_if push_if ();
  byte_stream_if pop_if ();

  ////////////////////////////////////////////////////////////////////////////
  // parts

  config_regs config_regs_inst (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .clear_i   (reg_clear),
    .wr_en_i   (reg_wr_en),
    .wr_idx_i  (q.widx),
    .wr_data_i (cmd_data_i),
    .rd_idx_i  (reg_rd_idx),
    .rd_data_o (reg_rd_data),
    .regs_o    (regs_all)
  );

  byte_buffer2 byte_buffer2_inst (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .in_s      (push_if.sink),
    .out_s     (pop_if.source)
  );

  ////////////////////////////////////////////////////////////////////////////
  // ports

  // commands held off until power-up wait ends
  assign cmd_ready_o      = (q.state == ST_IDLE) || (q.state == ST_WDATA);
  assign cmd_take         = cmd_valid_i && cmd_ready_o;
  assign reg_rd_idx       = cmd_reg_index(cmd_data_i);

  assign push_if.valid    = (q.state == ST_SEND);
  assign push_if.data     = q.shift[23:16];
  assign pop_if.ready     = rsp_ready_i;
  assign rsp_data_o       = pop_if.data;
  assign rsp_valid_o      = pop_if.valid;

  assign conv_run_o       = q.run;
  assign conv_start_o     = q.start_pulse;
  assign power_down_o     = q.pdown;
  assign result_ready_n_o = q.rdy_n;
  assign input_selector_o = q.sel;
  assign inputs_shorted_o = q.shorted;
  assign amp_bypass_o     = q.bypass;
  assign gain_code_o      = q.gain;
  assign config_o         = q.cfg;

  assign gain_field       = regs_all[REG_CONFIG0][GAIN_MSB:GAIN_LSB];
  assign bypass_field     = regs_all[REG_CONFIG0][BYPASS_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d             = q;
    d.start_pulse = 1'b0;
    reg_clear     = 1'b0;
    reg_wr_en     = 1'b0;

    unique case (q.state)
      ST_BOOT: begin
        if (q.boot_cnt == BOOT_LAST) begin
          d.state = ST_IDLE;
        end else begin
          d.boot_cnt = q.boot_cnt + 13'h1;
        end
      end

      ST_IDLE: begin
        if (cmd_take) begin
          if (cmd_data_i == CMD_RESET) begin
            reg_clear = 1'b1;
            d.run     = 1'b0;
            d.pdown   = 1'b0;
            d.rdy_n   = 1'b1;
            d.latest  = '0;
          end else if (cmd_data_i == CMD_START) begin
            d.run         = 1'b1;
            d.pdown       = 1'b0;
            d.start_pulse = 1'b1;
          end else if (cmd_data_i == CMD_SLEEP) begin
            d.run   = 1'b0;
            d.pdown = 1'b1;
          end else if (cmd_data_i == CMD_READ_DATA) begin
            d.shift = q.latest;
            d.left  = RESULT_BYTES;
            d.rdy_n = 1'b1;
            d.state = ST_SEND;
          end else if (cmd_data_i[7:4] == REG_WRITE_NIB) begin
            d.widx  = cmd_reg_index(cmd_data_i);
            d.state = ST_WDATA;
          end else if (cmd_data_i[7:4] == REG_READ_NIB) begin
            d.shift = {reg_rd_data, 16'h0000};
            d.left  = 2'h1;
            d.state = ST_SEND;
          end
        end
      end

      ST_WDATA: begin
        if (cmd_take) begin
          reg_wr_en = 1'b1;
          d.state   = ST_IDLE;
        end
      end

      ST_SEND: begin
        if (push_if.ready) begin
          d.shift = {q.shift[15:0], 8'h00};
          d.left  = q.left - 2'h1;
          if (q.left == 2'h1) begin
            d.state = ST_IDLE;
          end
        end
      end
    endcase

    // new result pulls ready low, wins over the read clear
    if (conv_done_i && q.run) begin
      d.latest = conv_result_i;
      d.rdy_n  = 1'b0;
      if (!regs_all[REG_CONFIG1][CONT_BIT]) begin
        d.run = 1'b0;
      end
    end

    d.sel = regs_all[REG_CONFIG0][SEL_MSB:SEL_LSB];
    d.shorted = (regs_all[REG_CONFIG0][SEL_MSB:SEL_LSB] == SEL_SHORTED);
    d.bypass = bypass_field;
    // bypassed amplifier limits gain to 4
    if (bypass_field && (gain_field > GAIN_CODE_4)) begin
      d.gain = GAIN_CODE_4;
    end else begin
      // codes up to 32 and beyond pass with amplifier on
      d.gain = gain_field;
    end
    d.cfg = regs_all;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q       <= '0;
      q.state <= ST_BOOT;
      q.rdy_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

endmodule : adc_command_sequencer

// ### host_model.sv
// host-side response taker: collects bytes, can stall
`timescale 1ns/100ps
module host_model (
  input  wire logic       clk_i,
  input  wire logic       stall_i,
  input  wire logic [7:0] rsp_data_i,
  input  wire logic       rsp_valid_i,
  output logic            rsp_ready_o
);
  logic [7:0] rxq[$];
  assign rsp_ready_o = !stall_i;
  always @(posedge clk_i) begin
    if (rsp_valid_i && rsp_ready_o) begin
      rxq.push_back(rsp_data_i);
    end
  end
endmodule : host_model

// ### adc_seq_sva.sv
// port-level checks of the command sequencer, bound to its top
`timescale 1ns/100ps
module adc_seq_sva
  import adc_seq_pkg::*;
#(
  parameter int unsigned POWER_UP_CYCLES = POWER_UP_CYCLES_DEFAULT
)
(
  input wire logic                      clk_i,
  input wire logic                      sys_rst_i,
  input wire logic [7:0]                cmd_data_i,
  input wire logic                      cmd_valid_i,
  input wire logic                      cmd_ready_o,
  input wire logic [7:0]                rsp_data_o,
  input wire logic                      rsp_valid_o,
  input wire logic                      rsp_ready_i,
  input wire logic                      conv_done_i,
  input wire logic                      conv_run_o,
  input wire logic                      conv_start_o,
  input wire logic                      power_down_o,
  input wire logic                      result_ready_n_o,
  input wire logic [3:0]                input_selector_o,
  input wire logic                      inputs_shorted_o,
  input wire logic                      amp_bypass_o,
  input wire logic [2:0]                gain_code_o,
  input wire logic [REG_COUNT-1:0][7:0] config_o
);
  logic [15:0] boot_cnt_q;
  logic        wdat_q;
  logic [1:0]  wix_q;
  logic        tk;
  logic        cmdtk;
  assign tk    = cmd_valid_i && cmd_ready_o;
  assign cmdtk = tk && !wdat_q;
  // edges since reset, data-byte tracking
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      boot_cnt_q <= 16'h0000;
      wdat_q     <= 1'b0;
      wix_q      <= 2'h0;
    end else begin
      if (boot_cnt_q != 16'hffff) boot_cnt_q <= boot_cnt_q + 16'h0001;
      if (tk) wdat_q <= cmdtk && (cmd_data_i[7:4] == REG_WRITE_NIB);
      if (cmdtk) wix_q <= cmd_data_i[3:2];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  boot_wait_a : assert property (
    boot_cnt_q <= POWER_UP_CYCLES |-> cmd_ready_o == (boot_cnt_q == POWER_UP_CYCLES)) else $error("boot wait wrong");
  rst_cmd_a : assert property (
    cmdtk && cmd_data_i == CMD_RESET |-> ##2 config_o == '0) else $error("reset command left config");
  reg_write_a : assert property (
    tk && wdat_q |-> ##2 config_o[$past(wix_q, 2)] == $past(cmd_data_i, 2)) else $error("register write lost");
  start_pulse_a : assert property (
    cmdtk && cmd_data_i == CMD_START |=> conv_start_o && conv_run_o ##1 !conv_start_o) else $error("start wrong");
  ready_fall_a : assert property (
    conv_done_i && conv_run_o |=> !result_ready_n_o) else $error("ready did not fall");
  read_clear_a : assert property (
    cmdtk && cmd_data_i == CMD_READ_DATA && !(conv_done_i && conv_run_o) |=> result_ready_n_o)
    else $error("ready not cleared by read");
  rsp_hold_a : assert property (
    rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_data_o)) else $error("stalled byte changed");
  sleep_cmd_a : assert property (
    cmdtk && cmd_data_i == CMD_SLEEP |=> power_down_o && !conv_run_o) else $error("sleep not entered");
  short_sel_a : assert property (
    inputs_shorted_o == (input_selector_o == SEL_SHORTED)) else $error("short flag wrong");
  gain_map_a : assert property (
    gain_code_o == ((amp_bypass_o && config_o[0][GAIN_MSB:GAIN_LSB] > GAIN_CODE_4) ? GAIN_CODE_4
                    : config_o[0][GAIN_MSB:GAIN_LSB])) else $error("gain code wrong");
  bypass_copy_a : assert property (
    amp_bypass_o == config_o[0][BYPASS_BIT] && input_selector_o == config_o[0][SEL_MSB:SEL_LSB])
    else $error("field copy wrong");
endmodule : adc_seq_sva
bind adc_command_sequencer adc_seq_sva #(.POWER_UP_CYCLES(POWER_UP_CYCLES)) adc_seq_sva_inst (
  .clk_i, .sys_rst_i, .cmd_data_i, .cmd_valid_i, .cmd_ready_o, .rsp_data_o, .rsp_valid_o, .rsp_ready_i,
  .conv_done_i, .conv_run_o, .conv_start_o, .power_down_o, .result_ready_n_o, .input_selector_o,
  .inputs_shorted_o, .amp_bypass_o, .gain_code_o, .config_o);

// ### tb_adc_command_sequencer.sv
// self-checking bench for the converter command sequencer
`timescale 1ns/100ps
module tb_adc_command_sequencer;
  import adc_seq_pkg::*;
  localparam int unsigned PUC = 8;
  logic                      clk_i = 1'b0, sys_rst_i = 1'b1, cmd_valid_i = 1'b0, conv_done_i = 1'b0, stall = 1'b0;
  logic [7:0]                cmd_data_i = 8'h00;
  logic [23:0]               conv_result_i = 24'h000000;
  logic [7:0]                rsp_data_o;
  logic                      cmd_ready_o, rsp_valid_o, rsp_ready_i, conv_run_o, conv_start_o, power_down_o;
  logic                      result_ready_n_o, inputs_shorted_o, amp_bypass_o;
  logic [3:0]                input_selector_o;
  logic [2:0]                gain_code_o;
  logic [REG_COUNT-1:0][7:0] config_o;
  int                        n_mismatch = 0, n_tests = 0;

  always #50 clk_i = ~clk_i;

  adc_command_sequencer #(.POWER_UP_CYCLES(PUC)) adc_command_sequencer_inst (
    .clk_i, .sys_rst_i, .cmd_data_i, .cmd_valid_i, .cmd_ready_o, .rsp_data_o, .rsp_valid_o, .rsp_ready_i,
    .conv_result_i, .conv_done_i, .conv_run_o, .conv_start_o, .power_down_o, .result_ready_n_o,
    .input_selector_o, .inputs_shorted_o, .amp_bypass_o, .gain_code_o, .config_o);
  host_model host_model_inst (.clk_i, .stall_i(stall), .rsp_data_i(rsp_data_o), .rsp_valid_i(rsp_valid_o),
    .rsp_ready_o(rsp_ready_i));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // bytes back to back, valid held until taken
  task automatic send(input logic [7:0] q[$]);
    int k;
    foreach (q[i]) begin
      cmd_data_i  = q[i];
      cmd_valid_i = 1'b1;
      k = 0;
      while (cmd_ready_o !== 1'b1 && k < 200) begin
        @(negedge clk_i);
        k++;
      end
      if (k >= 200) begin
        n_mismatch++;
      end
      @(negedge clk_i);
    end
    cmd_valid_i = 1'b0;
  endtask : send

  task automatic conv(input logic [23:0] v);
    conv_result_i = v;
    conv_done_i   = 1'b1;
    @(negedge clk_i);
    conv_done_i   = 1'b0;
  endtask : conv

  task automatic chk_rx(input logic [23:0] exp);
    int k;
    k = 0;
    while (host_model_inst.rxq.size() < 3 && k < 50) begin
      @(negedge clk_i);
      k++;
    end
    chk(host_model_inst.rxq.size(), 3);
    if (host_model_inst.rxq.size() >= 3) chk({host_model_inst.rxq[0], host_model_inst.rxq[1], host_model_inst.rxq[2]}, exp);
    host_model_inst.rxq.delete();
  endtask : chk_rx

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(3000 * 100);
    n_mismatch++;
    finish_test();
  end

  initial begin
    repeat (12) @(negedge clk_i);
    sys_rst_i = 1'b0;
    chk(result_ready_n_o, 1'b1);
    chk(rsp_valid_o, 1'b0);
    repeat (PUC - 1) @(negedge clk_i);
    chk(cmd_ready_o, 1'b0);
    repeat (2) @(negedge clk_i);
    chk(cmd_ready_o, 1'b1);
    send('{CMD_RESET, 8'h40, 8'h08, 8'h42, 8'h08, 8'h44, 8'h08, 8'h4c, 8'h5a});
    repeat (2) @(negedge clk_i);
    chk(config_o, 32'h5a000808);
    send('{8'h20, 8'h24, 8'h2c});
    chk_rx(24'h08085a);
    send('{8'h40, {SEL_SHORTED, GAIN_CODE_32, 1'b0}});
    repeat (2) @(negedge clk_i);
    chk(gain_code_o, GAIN_CODE_32);
    chk({input_selector_o, inputs_shorted_o, amp_bypass_o}, {SEL_SHORTED, 2'b10});
    send('{8'h40, {SEL_SHORTED, GAIN_CODE_32, 1'b1}});
    repeat (2) @(negedge clk_i);
    chk({gain_code_o, amp_bypass_o}, {GAIN_CODE_4, 1'b1});
    send('{CMD_START});
    chk({conv_start_o, conv_run_o, power_down_o}, 3'b110);
    conv(24'h812345);
    chk(result_ready_n_o, 1'b0);
    stall = 1'b1;
    send('{CMD_READ_DATA});
    repeat (4) @(negedge clk_i);
    chk({cmd_ready_o, result_ready_n_o}, 2'b01);
    stall = 1'b0;
    chk_rx(24'h812345);
    conv(24'h7ffffe);
    chk({conv_run_o, result_ready_n_o}, 2'b10);
    send('{CMD_READ_DATA});
    chk_rx(24'h7ffffe);
    chk(inputs_shorted_o, 1'b1);
    send('{8'h44, 8'h00, CMD_START});
    conv(24'hfffff0);
    chk({conv_run_o, result_ready_n_o}, 2'b00);
    send('{CMD_READ_DATA});
    chk_rx(24'hfffff0);
    conv(24'h111111);
    chk(result_ready_n_o, 1'b1);
    send('{CMD_SLEEP});
    chk({conv_run_o, power_down_o}, 2'b01);
    @(negedge clk_i);
    send('{CMD_RESET});
    repeat (2) @(negedge clk_i);
    chk(config_o, 32'h00000000);
    chk(power_down_o, 1'b0);
    finish_test();
  end
endmodule : tb_adc_command_sequencer
